// *** src/adcc_top.sv ***
// Converter input select and conversion control: registers, pin override,
// input routing, clock divider and conversion sequencer.
// Assumes Avalon-MM master on clk; analog core presents its result at end of conversion.
//
// Behaviour
// - A pin selected as analog input loses its digital function.
// - Pull-high resistor is dropped while the pin is an analog input.
// - Analog selection overrides the port direction setting.
// - Source codes 000 and 101-111 convert the channel-selected external input.
// - Channel codes 0000-0111 route analog channels 0 to 7.
// - Channel code 1xxx with external source connects nothing; input floats.
// - Source 001 with channel 1xxx connects the bandgap voltage.
// - Source codes 010-100 tie the converter input to ground.
// - Conversion starts only after start bit goes low, high, low.
// - Busy flag sets once a conversion is initiated.
// - Busy flag clears at completion for polling.
// - Completion sets interrupt flag; interrupt raised only when enabled.
// - Converter clock is system clock divided by two to the select value.
// - Power enable must be high to power the converter.
// - Conversion is four sampling plus twelve converting clocks, busy throughout.
// - Twelve-bit result readable from high and low registers after busy clears.
`timescale 1ns/1ps
`default_nettype none

module adcc_top
    import adcc_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // Avalon-MM slave
    input wire logic [7:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    // Pin function control
    output logic [ADCC_CHANNELS-1:0] pin_analog_en,
    output logic [ADCC_CHANNELS-1:0] pin_digital_en,
    output logic [ADCC_CHANNELS-1:0] pin_out_en,
    output logic [ADCC_CHANNELS-1:0] pin_pull_en,
    // Analog core
    output logic adc_power_en,
    output logic [ADCC_CHANNELS-1:0] adc_ch_switch,
    output logic adc_bandgap_switch,
    output logic adc_gnd_switch,
    output logic [1:0] adc_vref_sel,
    output logic adc_clk_tick,
    output logic adc_core_reset,
    output logic adc_sampling,
    output logic adc_converting,
    input wire logic [ADCC_RES_W-1:0] adc_result,
    // Interrupt request
    output logic adc_irq
);

    // Source decoding used by the input routing logic
    function automatic logic src_is_external(input logic [2:0] src);
        return (src == ADCC_SRC_EXT0) || (src > ADCC_SRC_GND_HI);
    endfunction

    function automatic logic src_is_ground(input logic [2:0] src);
        return (src >= ADCC_SRC_GND_LO) && (src <= ADCC_SRC_GND_HI);
    endfunction

    // Bus and register state
    adcc_cfg_type cfg_q, cfg_d;
    adcc_pin_type pin_q, pin_d;
    logic start_q, start_d;
    logic irq_flag_q, irq_flag_d;
    logic ack_q, ack_d;
    // Own flop so waitrequest is high straight out of reset
    logic wait_q;
    logic [31:0] rdata_q, rdata_d;

    // Sequencer state
    adcc_state_type state_q, state_d;
    logic [3:0] tick_cnt_q, tick_cnt_d;
    logic [ADCC_DIV_W-1:0] div_cnt_q, div_cnt_d;
    logic [ADCC_RES_W-1:0] result_q, result_d;
    logic done;
    logic tick;
    logic busy;

    // Registered outputs
    adcc_route_type route_q, route_d;
    logic [ADCC_CHANNELS-1:0] ana_q, dig_q, oe_q, pull_q;
    logic tick_q, core_rst_q, samp_q, conv_q, irq_q;

    logic wr_en, rd_en, wr_lane0;
    logic [ADCC_DIV_W-1:0] div_mask;

    assign busy = (state_q == ADCC_ST_SAMPLE) || (state_q == ADCC_ST_CONVERT);

    // Bus: one wait state, then a single accepted cycle
    always_comb begin
        ack_d = (avs_read || avs_write) && !ack_q;
        wr_en = avs_write && ack_d;
        rd_en = avs_read && ack_d;
        wr_lane0 = wr_en && avs_byteenable[0];
    end

    // Software-written registers and the start bit
    always_comb begin
        cfg_d = cfg_q;
        pin_d = pin_q;
        start_d = start_q;
        irq_flag_d = irq_flag_q;
        if (wr_lane0) begin
            unique case (avs_address)
                ADCC_OFS_CTRL0: begin
                    start_d = avs_writedata[ADCC_C0_START];
                    cfg_d.power_en = avs_writedata[ADCC_C0_PWR];
                    cfg_d.channel_sel = avs_writedata[ADCC_C0_CH_LSB +: 4];
                end
                ADCC_OFS_CTRL1: begin
                    cfg_d.input_source_sel = avs_writedata[ADCC_C1_SRC_LSB +: 3];
                    cfg_d.vref_sel = avs_writedata[ADCC_C1_VREF_LSB +: 2];
                    cfg_d.conv_clock_div_sel = avs_writedata[ADCC_C1_DIV_LSB +: 3];
                end
                ADCC_OFS_IRQ: begin
                    cfg_d.int_en = avs_writedata[ADCC_IRQ_EN];
                    if (avs_writedata[ADCC_IRQ_FLAG]) begin
                        irq_flag_d = 1'b0;
                    end
                end
                ADCC_OFS_PIN_ANA: pin_d.analog_sel = avs_writedata[ADCC_CHANNELS-1:0];
                ADCC_OFS_PIN_DIR: pin_d.dir_out = avs_writedata[ADCC_CHANNELS-1:0];
                ADCC_OFS_PIN_PULL: pin_d.pull_en = avs_writedata[ADCC_CHANNELS-1:0];
                default: begin
                end
            endcase
        end
        // Completion wins over a same-cycle clear
        if (done) begin
            irq_flag_d = 1'b1;
        end
    end

    // Read mux; unmapped offsets read as zero
    always_comb begin
        rdata_d = rdata_q;
        if (rd_en) begin
            rdata_d = ADCC_RST_WORD;
            unique case (avs_address)
                ADCC_OFS_CTRL0: begin
                    rdata_d[ADCC_C0_START] = start_q;
                    rdata_d[ADCC_C0_BUSY] = busy;
                    rdata_d[ADCC_C0_PWR] = cfg_q.power_en;
                    rdata_d[ADCC_C0_CH_LSB +: 4] = cfg_q.channel_sel;
                end
                ADCC_OFS_CTRL1: begin
                    rdata_d[ADCC_C1_SRC_LSB +: 3] = cfg_q.input_source_sel;
                    rdata_d[ADCC_C1_VREF_LSB +: 2] = cfg_q.vref_sel;
                    rdata_d[ADCC_C1_DIV_LSB +: 3] = cfg_q.conv_clock_div_sel;
                end
                ADCC_OFS_RES_HI: rdata_d[3:0] = result_q[ADCC_RES_W-1:8];
                ADCC_OFS_RES_LO: rdata_d[7:0] = result_q[7:0];
                ADCC_OFS_IRQ: begin
                    rdata_d[ADCC_IRQ_FLAG] = irq_flag_q;
                    rdata_d[ADCC_IRQ_EN] = cfg_q.int_en;
                end
                ADCC_OFS_PIN_ANA: rdata_d[ADCC_CHANNELS-1:0] = pin_q.analog_sel;
                ADCC_OFS_PIN_DIR: rdata_d[ADCC_CHANNELS-1:0] = pin_q.dir_out;
                ADCC_OFS_PIN_PULL: rdata_d[ADCC_CHANNELS-1:0] = pin_q.pull_en;
                default: begin
                end
            endcase
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            cfg_q <= '0;
            pin_q <= '0;
            start_q <= 1'b0;
            irq_flag_q <= 1'b0;
            ack_q <= 1'b0;
            wait_q <= 1'b1;
            rdata_q <= ADCC_RST_WORD;
        end else begin
            cfg_q <= cfg_d;
            pin_q <= pin_d;
            start_q <= start_d;
            irq_flag_q <= irq_flag_d;
            ack_q <= ack_d;
            wait_q <= !ack_d;
            rdata_q <= rdata_d;
        end
    end

    // Converter clock: one-cycle tick every 2**sel system clocks
    always_comb begin
        div_mask = ADCC_DIV_W'((8'h01 << cfg_q.conv_clock_div_sel) - 8'h01);
        div_cnt_d = cfg_q.power_en ? div_cnt_q + 1'b1 : '0;
        tick = cfg_q.power_en && ((div_cnt_q & div_mask) == div_mask);
    end

    // Sequencer: rise of start arms and resets, fall launches
    always_comb begin
        state_d = state_q;
        tick_cnt_d = tick_cnt_q;
        result_d = result_q;
        done = 1'b0;
        unique case (state_q)
            ADCC_ST_IDLE: begin
                if (start_d && !start_q) begin
                    state_d = ADCC_ST_ARMED;
                end
            end
            ADCC_ST_ARMED: begin
                if (!start_d) begin
                    state_d = ADCC_ST_SAMPLE;
                    tick_cnt_d = '0;
                end
            end
            ADCC_ST_SAMPLE: begin
                if (tick) begin
                    tick_cnt_d = tick_cnt_q + 1'b1;
                    if (tick_cnt_q == ADCC_SAMPLE_CYCLES - 4'h1) begin
                        state_d = ADCC_ST_CONVERT;
                        tick_cnt_d = '0;
                    end
                end
            end
            ADCC_ST_CONVERT: begin
                if (tick) begin
                    tick_cnt_d = tick_cnt_q + 1'b1;
                    if (tick_cnt_q == ADCC_CONV_CYCLES - 4'h1) begin
                        state_d = ADCC_ST_IDLE;
                        result_d = adc_result;
                        done = 1'b1;
                    end
                end
            end
        endcase
        // A new start rise mid-conversion restarts the sequence
        if (busy && start_d && !start_q) begin
            state_d = ADCC_ST_ARMED;
        end
        // Power removal aborts without completion
        if (!cfg_q.power_en) begin
            state_d = ADCC_ST_IDLE;
            done = 1'b0;
            result_d = result_q;
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            state_q <= ADCC_ST_IDLE;
            tick_cnt_q <= '0;
            div_cnt_q <= '0;
            result_q <= '0;
        end else begin
            state_q <= state_d;
            tick_cnt_q <= tick_cnt_d;
            div_cnt_q <= div_cnt_d;
            result_q <= result_d;
        end
    end

    // Routing and pin override; switches open when unpowered to avoid shorts
    always_comb begin
        route_d = '0;
        if (cfg_q.power_en) begin
            if (src_is_external(cfg_q.input_source_sel) && !cfg_q.channel_sel[3]) begin
                route_d.ch_switch[cfg_q.channel_sel[2:0]] = 1'b1;
            end
            route_d.bandgap_switch = (cfg_q.input_source_sel == ADCC_SRC_BANDGAP)
                && cfg_q.channel_sel[3];
            route_d.gnd_switch = src_is_ground(cfg_q.input_source_sel);
        end
        // Channel code 1xxx with an external source leaves every switch open
        if (src_is_external(cfg_q.input_source_sel) && cfg_q.channel_sel[3]) begin
            route_d.ch_switch = '0;
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            route_q <= '0;
            ana_q <= '0;
            dig_q <= '0;
            oe_q <= '0;
            pull_q <= '0;
            tick_q <= 1'b0;
            core_rst_q <= 1'b0;
            samp_q <= 1'b0;
            conv_q <= 1'b0;
            irq_q <= 1'b0;
        end else begin
            route_q <= route_d;
            ana_q <= pin_d.analog_sel;
            dig_q <= ~pin_d.analog_sel;
            oe_q <= pin_d.dir_out & ~pin_d.analog_sel;
            pull_q <= pin_d.pull_en & ~pin_d.analog_sel;
            tick_q <= tick;
            core_rst_q <= (state_d == ADCC_ST_ARMED);
            samp_q <= (state_d == ADCC_ST_SAMPLE);
            conv_q <= (state_d == ADCC_ST_CONVERT);
            irq_q <= irq_flag_d && cfg_d.int_en;
        end
    end

    assign avs_readdata = rdata_q;
    assign avs_waitrequest = wait_q;
    assign pin_analog_en = ana_q;
    assign pin_digital_en = dig_q;
    assign pin_out_en = oe_q;
    assign pin_pull_en = pull_q;
    assign adc_power_en = cfg_q.power_en;
    assign adc_ch_switch = route_q.ch_switch;
    assign adc_bandgap_switch = route_q.bandgap_switch;
    assign adc_gnd_switch = route_q.gnd_switch;
    assign adc_vref_sel = cfg_q.vref_sel;
    assign adc_clk_tick = tick_q;
    assign adc_core_reset = core_rst_q;
    assign adc_sampling = samp_q;
    assign adc_converting = conv_q;
    assign adc_irq = irq_q;

endmodule // adcc_top

`default_nettype wire

// *** src/adcc_pkg.sv ***
// Package for the converter input select and conversion control block.
// Assumes a single 10 MHz system clock and byte-addressed 32-bit Avalon-MM access.
package adcc_pkg;

    // Register byte offsets
    localparam logic [7:0] ADCC_OFS_CTRL0 = 8'h00;
    localparam logic [7:0] ADCC_OFS_CTRL1 = 8'h04;
    localparam logic [7:0] ADCC_OFS_RES_HI = 8'h08;
    localparam logic [7:0] ADCC_OFS_RES_LO = 8'h0C;
    localparam logic [7:0] ADCC_OFS_IRQ = 8'h10;
    localparam logic [7:0] ADCC_OFS_PIN_ANA = 8'h14;
    localparam logic [7:0] ADCC_OFS_PIN_DIR = 8'h18;
    localparam logic [7:0] ADCC_OFS_PIN_PULL = 8'h1C;

    // Control register 0 fields
    localparam int ADCC_C0_START = 7;
    localparam int ADCC_C0_BUSY = 6;
    localparam int ADCC_C0_PWR = 5;
    localparam int ADCC_C0_CH_LSB = 0;
    // Control register 1 fields
    localparam int ADCC_C1_SRC_LSB = 5;
    localparam int ADCC_C1_VREF_LSB = 3;
    localparam int ADCC_C1_DIV_LSB = 0;
    // Interrupt register fields
    localparam int ADCC_IRQ_FLAG = 0;
    localparam int ADCC_IRQ_EN = 1;

    // Reset values
    localparam logic [7:0] ADCC_RST_BYTE = 8'h00;
    localparam logic [31:0] ADCC_RST_WORD = 32'h0000_0000;

    // Input source select codes
    localparam logic [2:0] ADCC_SRC_EXT0 = 3'h0;
    localparam logic [2:0] ADCC_SRC_BANDGAP = 3'h1;
    localparam logic [2:0] ADCC_SRC_GND_LO = 3'h2;
    localparam logic [2:0] ADCC_SRC_GND_HI = 3'h4;

    // Conversion timing in converter clock cycles, then result width, channel count and divider width
    localparam logic [3:0] ADCC_SAMPLE_CYCLES = 4'h4;
    localparam logic [3:0] ADCC_CONV_CYCLES = 4'hC;
    localparam int ADCC_RES_W = 12;
    localparam int ADCC_CHANNELS = 8;
    localparam int ADCC_DIV_W = 7;

    typedef enum logic [1:0] {
        ADCC_ST_IDLE,
        ADCC_ST_ARMED,
        ADCC_ST_SAMPLE,
        ADCC_ST_CONVERT
    } adcc_state_type;

    typedef struct packed {
        logic power_en;
        logic [3:0] channel_sel;
        logic [2:0] input_source_sel;
        logic [1:0] vref_sel;
        logic [2:0] conv_clock_div_sel;
        logic int_en;
    } adcc_cfg_type;

    typedef struct packed {
        logic [ADCC_CHANNELS-1:0] analog_sel;
        logic [ADCC_CHANNELS-1:0] dir_out;
        logic [ADCC_CHANNELS-1:0] pull_en;
    } adcc_pin_type;

    typedef struct packed {
        logic [ADCC_CHANNELS-1:0] ch_switch;
        logic bandgap_switch;
        logic gnd_switch;
    } adcc_route_type;

endpackage : adcc_pkg

// *** tb/adcc_checker.sv ***
// Port-level assertions for the converter control block.
// Assumes one clock domain and binding onto adcc_top.
`timescale 1ns/1ps
`default_nettype none
module adcc_checker
    import adcc_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // Bus
    input wire logic avs_write,
    // Pins
    input wire logic [ADCC_CHANNELS-1:0] pin_analog_en,
    input wire logic [ADCC_CHANNELS-1:0] pin_digital_en,
    input wire logic [ADCC_CHANNELS-1:0] pin_out_en,
    input wire logic [ADCC_CHANNELS-1:0] pin_pull_en,
    // Core
    input wire logic adc_power_en,
    input wire logic [ADCC_CHANNELS-1:0] adc_ch_switch,
    input wire logic adc_bandgap_switch,
    input wire logic adc_gnd_switch,
    input wire logic adc_clk_tick,
    input wire logic adc_core_reset,
    input wire logic adc_sampling,
    input wire logic adc_converting,
    input wire logic adc_irq
);
    default clocking @(posedge clk); endclocking
    default disable iff (!reset_n);
    logic [4:0] tick_q;
    logic [4:0] tick_d;
    logic busy_prev_q;
    // Tick pin lags the sequencer by a cycle, so count it one cycle late
    always_comb begin
        tick_d = 5'h00;
        if (busy_prev_q) begin
            tick_d = tick_q + 5'(adc_clk_tick);
        end
    end
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            tick_q <= 5'h00;
            busy_prev_q <= 1'b0;
        end else begin
            tick_q <= tick_d;
            busy_prev_q <= adc_sampling || adc_converting;
        end
    end
    // Aborts by power loss or re-arm are excluded
    sequence s_sample_end;
        $fell(adc_sampling) && adc_power_en && !adc_core_reset;
    endsequence
    sequence s_conv_end;
        $fell(adc_converting) && adc_power_en && !adc_core_reset;
    endsequence
    a_pin_digital_off: assert property ((pin_analog_en & pin_digital_en) == 8'h00)
        else $error("digital function left on for analog pin");
    a_pin_pull_drop: assert property ((pin_analog_en & pin_pull_en) == 8'h00)
        else $error("pull-high left on for analog pin");
    a_pin_dir_override: assert property ((pin_analog_en & pin_out_en) == 8'h00)
        else $error("output driver left on for analog pin");
    a_route_exclusive: assert property ($onehot0({adc_ch_switch, adc_bandgap_switch, adc_gnd_switch}))
        else $error("two converter input sources closed together");
    a_sample_four: assert property (s_sample_end |-> adc_converting && tick_d == 5'h04)
        else $error("sampling phase not four converter clocks");
    a_conv_sixteen: assert property (s_conv_end |-> tick_d == 5'h10)
        else $error("conversion not sixteen converter clocks");
    a_launch_armed: assert property ($rose(adc_sampling) |-> $fell(adc_core_reset))
        else $error("conversion began without start rise and fall");
    a_irq_cause: assert property ($rose(adc_irq) |-> $fell(adc_converting) || $past(avs_write))
        else $error("interrupt rose without completion or write");
    a_power_off: assert property (!adc_power_en && !$past(adc_power_en) |->
        !adc_clk_tick && !adc_sampling && !adc_converting && adc_ch_switch == 8'h00)
        else $error("converter active while unpowered");
endmodule // adcc_checker
bind adcc_top adcc_checker adcc_checker_i (.clk, .reset_n, .avs_write, .pin_analog_en, .pin_digital_en,
    .pin_out_en, .pin_pull_en, .adc_power_en, .adc_ch_switch, .adc_bandgap_switch, .adc_gnd_switch,
    .adc_clk_tick, .adc_core_reset, .adc_sampling, .adc_converting, .adc_irq);
`default_nettype wire

// *** tb/adcc_core_model.sv ***
// Behavioural analog converter core.
// Assumes the block samples the result at the last converting tick.
`timescale 1ns/1ps
`default_nettype none
module adcc_core_model
    import adcc_pkg::*;
(
    // Clock
    input wire logic clk,
    // Controls
    input wire logic adc_power_en,
    input wire logic [ADCC_CHANNELS-1:0] adc_ch_switch,
    input wire logic adc_bandgap_switch,
    input wire logic adc_converting,
    // Result
    output logic [ADCC_RES_W-1:0] adc_result
);
    logic [11:0] val;
    logic flip_q = 1'b0;
    always_comb begin
        // Unpowered reads full scale; powered with no channel reads zero
        val = 12'hFFF;
        if (adc_bandgap_switch) begin
            val = 12'h4B2;
        end else if (adc_power_en) begin
            val = 12'h000;
            for (int k = 0; k < ADCC_CHANNELS; k++) begin
                if (adc_ch_switch[k]) begin
                    val = 12'h5A0 + 12'(k);
                end
            end
        end
    end
    always_ff @(posedge clk) begin
        flip_q <= !flip_q;
    end
    // Outside a powered conversion the value is junk that toggles
    assign adc_result = (adc_power_en && adc_converting) || flip_q ? val : ~val;
endmodule // adcc_core_model
`default_nettype wire

// *** tb/tb_adcc_top.sv ***
// Self-checking bench for the converter control block.
// Assumes the core model and the bound checker.
`timescale 1ns/1ps
`default_nettype none
module tb_adcc_top
    import adcc_pkg::*;
;
    logic clk, reset_n, avs_read, avs_write, avs_waitrequest, adc_power_en, adc_bandgap_switch, adc_gnd_switch;
    logic adc_clk_tick, adc_core_reset, adc_sampling, adc_converting, adc_irq;
    logic [7:0] avs_address, pin_analog_en, pin_digital_en, pin_out_en, pin_pull_en, adc_ch_switch;
    logic [31:0] avs_writedata, avs_readdata, rdata;
    logic [3:0] avs_byteenable;
    logic [1:0] adc_vref_sel;
    logic [11:0] adc_result;
    int failures = 0, total_checks = 0, cycles = 0, n;
    logic [7:0] t_c1 [3] = '{8'h03, 8'h24, 8'h45};
    logic [3:0] t_ch [3] = '{4'h1, 4'h8, 4'h8};
    logic [11:0] t_res [3] = '{12'h5A1, 12'h4B2, 12'h000};
    adcc_top adcc_top_i (.clk, .reset_n, .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_byteenable,
        .avs_readdata, .avs_waitrequest, .pin_analog_en, .pin_digital_en, .pin_out_en, .pin_pull_en,
        .adc_power_en, .adc_ch_switch, .adc_bandgap_switch, .adc_gnd_switch, .adc_vref_sel, .adc_clk_tick,
        .adc_core_reset, .adc_sampling, .adc_converting, .adc_result, .adc_irq);
    adcc_core_model adcc_core_model_i (.clk, .adc_power_en, .adc_ch_switch, .adc_bandgap_switch,
        .adc_converting, .adc_result);
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    task automatic final_report;
        $display("checks %0d failures %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            failures++;
            final_report();
        end
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            failures++;
            $display("FAIL %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    // Held until waitrequest is sampled low, released after
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        avs_address <= a;
        avs_write <= wr;
        avs_read <= !wr;
        avs_writedata <= wd;
        do @(posedge clk); while (avs_waitrequest !== 1'b0);
        rdata = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
        @(posedge clk);
    endtask
    initial begin
        logic [9:0] sw;
        reset_n = 1'b0;
        avs_address = 8'h00;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_writedata = 32'h0000_0000;
        avs_byteenable = 4'hF;
        repeat (20) @(posedge clk);
        check(32'(avs_waitrequest), 32'h1);
        reset_n <= 1'b1;
        for (int a = 0; a <= 8'h20; a += 4) begin
            bus(0, 8'(a), 0);
            check(rdata, 32'h0000_0000);
        end
        $display("test reset done");
        bus(1, ADCC_OFS_PIN_DIR, 32'h0000_00FF);
        bus(1, ADCC_OFS_PIN_PULL, 32'h0000_00FF);
        bus(1, ADCC_OFS_PIN_ANA, 32'h0000_000F);
        check({pin_analog_en, pin_digital_en, pin_out_en, pin_pull_en}, 32'h0FF0_F0F0);
        bus(1, ADCC_OFS_PIN_ANA, 32'h0000_0000);
        check({pin_analog_en, pin_digital_en, pin_out_en, pin_pull_en}, 32'h00FF_FFFF);
        $display("test pins done");
        bus(1, ADCC_OFS_CTRL0, 32'h0000_0020);
        repeat (50) @(posedge clk);
        for (int s = 0; s < 8; s++) begin
            for (int c = 0; c < 16; c++) begin
                if (s == 1 && c < 8) continue;
                bus(1, ADCC_OFS_CTRL1, 32'(s << 5));
                bus(1, ADCC_OFS_CTRL0, 32'(8'h20 | c));
                sw = {(s == 0 || s > 4) && c < 8 ? 8'(1 << c) : 8'h00, s == 1 && c > 7, s > 1 && s < 5};
                check(32'({adc_ch_switch, adc_bandgap_switch, adc_gnd_switch}), 32'(sw));
            end
        end
        $display("test routing done");
        bus(1, ADCC_OFS_CTRL1, 32'h0000_001B);
        avs_byteenable <= 4'h0;
        bus(1, ADCC_OFS_CTRL1, 32'h0000_0000);
        avs_byteenable <= 4'hF;
        bus(0, ADCC_OFS_CTRL1, 0);
        check(rdata, 32'h0000_001B);
        check(32'(adc_vref_sel), 32'h3);
        $display("test lane refuse done");
        for (int i = 0; i < 3; i++) begin
            bus(1, ADCC_OFS_CTRL0, 32'h0000_0028);
            bus(1, ADCC_OFS_CTRL1, 32'(t_c1[i]));
            bus(1, ADCC_OFS_IRQ, {30'h0, i != 1, 1'b1});
            bus(1, ADCC_OFS_CTRL0, 32'h20 | 32'(t_ch[i]));
            bus(0, ADCC_OFS_CTRL0, 0);
            check(32'(rdata[6]), 32'h0);
            do @(posedge clk); while (adc_clk_tick !== 1'b1);
            n = 0;
            do begin
                @(posedge clk);
                n++;
            end while (adc_clk_tick !== 1'b1);
            check(n, 32'h1 << t_c1[i][2:0]);
            bus(1, ADCC_OFS_CTRL0, 32'hA0 | 32'(t_ch[i]));
            check(32'(adc_core_reset), 32'h1);
            bus(1, ADCC_OFS_CTRL0, 32'h20 | 32'(t_ch[i]));
            bus(0, ADCC_OFS_CTRL0, 0);
            check(32'(rdata[6]), 32'h1);
            do bus(0, ADCC_OFS_CTRL0, 0); while (rdata[6] !== 1'b0);
            check(32'(adc_irq), 32'(i != 1));
            bus(0, ADCC_OFS_IRQ, 0);
            check(rdata, {30'h0, i != 1, 1'b1});
            bus(0, ADCC_OFS_RES_HI, 0);
            check(rdata, 32'(t_res[i][11:8]));
            bus(0, ADCC_OFS_RES_LO, 0);
            check(rdata, 32'(t_res[i][7:0]));
            $display("test conversion %0d done", i);
        end
        bus(1, ADCC_OFS_IRQ, 32'h0000_0003);
        check(32'(adc_irq), 32'h0);
        bus(1, ADCC_OFS_CTRL0, 32'h0000_00A1);
        bus(1, ADCC_OFS_CTRL0, 32'h0000_0021);
        bus(1, ADCC_OFS_CTRL0, 32'h0000_0001);
        bus(0, ADCC_OFS_CTRL0, 0);
        check(rdata, 32'h0000_0001);
        bus(0, ADCC_OFS_IRQ, 0);
        check(rdata, 32'h0000_0002);
        $display("test abort done");
        final_report();
    end
endmodule // tb_adcc_top
`default_nettype wire
